// ### logic/alp_pkg.sv
// Shared constants and types for the low-power converter control block
package alp_pkg;

   // Register byte offsets on the bus
   localparam int ALP_AW = 8;
   localparam logic [7:0] ALP_OFS_CFG = 8'h00;
   localparam logic [7:0] ALP_OFS_SC2 = 8'h04;
   localparam logic [7:0] ALP_OFS_SC1 = 8'h08;
   localparam logic [7:0] ALP_OFS_RH = 8'h0C;
   localparam logic [7:0] ALP_OFS_RL = 8'h10;
   localparam logic [7:0] ALP_OFS_CVH = 8'h14;
   localparam logic [7:0] ALP_OFS_CVL = 8'h18;
   localparam logic [7:0] ALP_OFS_PC1 = 8'h1C;
   localparam logic [7:0] ALP_OFS_PC2 = 8'h20;

   // Reset values
   localparam logic [7:0] ALP_CFG_RST = 8'h00;
   localparam logic [7:0] ALP_SC2_RST = 8'h00;
   localparam logic [7:0] ALP_SC1_RST = 8'h1F;
   localparam logic [7:0] ALP_CV_RST = 8'h00;
   localparam logic [7:0] ALP_PC_RST = 8'h00;
   localparam logic [9:0] ALP_RES_RST = 10'h000;

   // Encodings
   localparam int ALP_BYTE_W = 8;
   localparam int ALP_RES_W = 10;
   localparam logic [1:0] ALP_MODE_10BIT = 2'h2;
   localparam logic [1:0] ALP_CLK_BUS = 2'h0;
   localparam logic [1:0] ALP_CLK_ASYNC = 2'h3;
   localparam logic [1:0] ALP_DIV_1 = 2'h0;
   localparam logic [4:0] ALP_CH_OFF = 5'h1F;
   localparam logic [1:0] ALP_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] ALP_HTRANS_SEQ = 2'h3;

   // Field layouts, msb first
   typedef struct packed {
      logic low_power_select;
      logic [1:0] clock_divider;
      logic long_sample_select;
      logic [1:0] mode;
      logic [1:0] input_clock_select;
   } alp_cfg_t;

   typedef struct packed {
      logic conv_active_flag;
      logic trigger_select;
      logic compare_enable;
      logic compare_greater_select;
      logic [1:0] unimpl;
      logic [1:0] rsvd;
   } alp_sc2_t;

   typedef struct packed {
      logic conv_complete_flag;
      logic complete_irq_enable;
      logic continuous_select;
      logic [4:0] channel_select;
   } alp_sc1_t;

   typedef struct packed {
      alp_cfg_t cfg;
      alp_sc2_t sc2;
      alp_sc1_t sc1;
      logic [7:0] cvh;
      logic [7:0] cvl;
      logic [7:0] pc1;
      logic [7:0] pc2;
   } alp_regs_t;

   // System inputs crossing in from the power controller and trigger pin
   typedef struct packed {
      logic stop3;
      logic deep_stop;
      logic hw_trig;
   } alp_sys_t;

   typedef enum logic [0:0] {
      ALP_IDLE = 1'b0,
      ALP_CONV = 1'b1
   } alp_state_t;

endpackage : alp_pkg

// ### logic/alp_sync.sv
// Two-flop synchroniser for a bundle of level inputs
`timescale 1ns/1ps
`default_nettype none
module alp_sync #(
   parameter int W = 3
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         meta_ff <= '0;
         q_ff <= '0;
      end
      else
      begin
         meta_ff <= d;
         q_ff <= meta_ff;
      end
   end

   assign q = q_ff;
endmodule : alp_sync
`default_nettype wire

// ### logic/alp_ctrl.sv
// Converter control: registers, conversion sequencing and stop-mode handling
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [RULE1] Stop3 without async clock aborts conversion, converter goes idle.
// [RULE2] Stop3 leaves both result bytes untouched.
// [RULE3] After an abort in stop3, only a new trigger restarts conversion.
// [RULE4] With async clock selected, converter keeps running in stop3.
// [RULE5] Running conversion finishes when stop3 entered with async clock.
// [RULE6] In stop3 with async clock, hardware trigger or continuous mode start conversions.
// [RULE7] Completion sets complete flag; interrupt out when enable is set.
// [RULE8] Software clears result blocking before stop3 with running conversions.
// [RULE9] Stop1/stop2 disables converter and returns all registers to reset.
// [RULE10] Software configures configuration, then second, then first status register.
// [RULE11] Configuration holds low power, divider, sample, resolution, clock fields.
// [RULE12] Second status register holds active, trigger, compare enable, greater fields.
// [RULE13] Second status bits 3:2 read zero; bits 1:0 reserved, write zero.
// [RULE14] First status holds complete flag, interrupt enable and channel fields.
// [RULE15] Continuous bit chooses single or repeated conversions.
// [RULE16] High byte read first; in 10-bit mode pair protected from next result.
// [RULE17] Compare value pair holds threshold for automatic compare.
// [RULE18] Pin control bit set disables that pin's general purpose I/O.
// [RULE19] First status write aborts; restarts unless channel all ones or hardware trigger selected.
// [RULE20] In 10-bit mode, blocked result is discarded, flag stays clear.
// [RULE21] Separate stop3 and stop1/stop2 inputs select abort, continue or reset.
module alp_ctrl
   import alp_pkg::*;
#(
   parameter int PINS = 16
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic stop3_req,
   input wire logic deep_stop_req,
   input wire logic hw_trig,
   input wire logic conv_done,
   input wire logic [ALP_RES_W-1:0] conv_data,
   output logic conv_start,
   output logic conv_abort,
   output logic [4:0] conv_channel,
   output alp_cfg_t conv_cfg,
   output logic conv_irq,
   output logic [PINS-1:0] pin_analog_en
);

   alp_sys_t sys_raw;
   alp_sys_t sys_s;

   alp_regs_t regs_ff;
   alp_regs_t nxt_regs;
   logic [ALP_RES_W-1:0] result_ff;
   logic [ALP_RES_W-1:0] nxt_result;
   logic block_ff;
   logic nxt_block;
   alp_state_t st_ff;
   alp_state_t nxt_st;
   logic start_ff;
   logic nxt_start;
   logic abort_ff;
   logic nxt_abort;
   logic [ALP_AW-1:0] addr_ff;
   logic [ALP_AW-1:0] nxt_addr;
   logic wr_ff;
   logic nxt_wr;
   logic [31:0] hrdata_ff;
   logic [31:0] nxt_hrdata;
   logic trig_ff;
   logic nxt_trig;
   logic stop3_ff;
   logic nxt_stop3;

   logic ph_ok;
   logic async_sel;
   logic halted;
   logic start_req;
   logic abort_req;
   logic set_conv_complete_flag;
   logic clr_conv_complete_flag;
   logic [ALP_RES_W-1:0] res_now;
   logic [ALP_RES_W-1:0] cmp_val;
   logic cmp_true;
   logic [7:0] wbyte;
   alp_sc1_t wsc1;
   alp_sc2_t wsc2;

   function automatic alp_regs_t regs_reset();
      alp_regs_t r;
      r.cfg = alp_cfg_t'(ALP_CFG_RST);
      r.sc2 = alp_sc2_t'(ALP_SC2_RST);
      r.sc1 = alp_sc1_t'(ALP_SC1_RST);
      r.cvh = ALP_CV_RST;
      r.cvl = ALP_CV_RST;
      r.pc1 = ALP_PC_RST;
      r.pc2 = ALP_PC_RST;
      return r;
   endfunction : regs_reset

   // High or low byte of a 10-bit word
   function automatic logic [7:0] hi_byte(input logic [ALP_RES_W-1:0] v);
      return 8'(v >> ALP_BYTE_W);
   endfunction : hi_byte

   function automatic logic [7:0] lo_byte(input logic [ALP_RES_W-1:0] v);
      return v[ALP_BYTE_W-1:0];
   endfunction : lo_byte

   // Read data for an address; unmapped reads as zero
   function automatic logic [31:0] rd_mux(
      input logic [ALP_AW-1:0] a,
      input alp_regs_t r,
      input logic [ALP_RES_W-1:0] res,
      input logic act
   );
      alp_sc2_t s2;
      logic [7:0] b;
      s2 = r.sc2;
      s2.conv_active_flag = act; // see [RULE12]
      s2.unimpl = '0; // see [RULE13]
      s2.rsvd = '0; // see [RULE13]
      case (a)
         ALP_OFS_CFG: b = r.cfg; // see [RULE11]
         ALP_OFS_SC2: b = s2;
         ALP_OFS_SC1: b = r.sc1; // see [RULE14]
         ALP_OFS_RH: b = hi_byte(res);
         ALP_OFS_RL: b = lo_byte(res);
         ALP_OFS_CVH: b = r.cvh;
         ALP_OFS_CVL: b = r.cvl;
         ALP_OFS_PC1: b = r.pc1;
         ALP_OFS_PC2: b = r.pc2;
         default: b = '0;
      endcase
      return 32'(b);
   endfunction : rd_mux

   alp_sync #(
      .W($bits(alp_sys_t))
   ) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .d(sys_raw),
      .q(sys_s)
   );

   assign sys_raw.stop3 = stop3_req;
   assign sys_raw.deep_stop = deep_stop_req;
   assign sys_raw.hw_trig = hw_trig;

   assign ph_ok = hsel && hready
      && ((htrans == ALP_HTRANS_NONSEQ) || (htrans == ALP_HTRANS_SEQ));
   assign async_sel = (regs_ff.cfg.input_clock_select == ALP_CLK_ASYNC);
   // Conversion clock stopped while in stop3 on a synchronous source
   assign halted = sys_s.stop3 && !async_sel; // see [RULE3] [RULE4]
   assign wbyte = hwdata[ALP_BYTE_W-1:0];
   assign wsc1 = alp_sc1_t'(wbyte);
   assign wsc2 = alp_sc2_t'(wbyte);

   // 8-bit mode keeps the low byte of the analog result
   assign res_now = (regs_ff.cfg.mode == ALP_MODE_10BIT) ? conv_data
      : ALP_RES_W'(lo_byte(conv_data));
   assign cmp_val = ALP_RES_W'({regs_ff.cvh, regs_ff.cvl});
   assign cmp_true = regs_ff.sc2.compare_greater_select ? (res_now >= cmp_val)
      : (res_now < cmp_val); // see [RULE17]

   always_comb
   begin
      nxt_regs = regs_ff;
      nxt_result = result_ff;
      nxt_block = block_ff;
      nxt_st = st_ff;
      nxt_start = 1'b0;
      nxt_abort = 1'b0;
      nxt_addr = addr_ff;
      nxt_wr = 1'b0;
      nxt_hrdata = hrdata_ff;
      nxt_trig = sys_s.hw_trig;
      nxt_stop3 = sys_s.stop3;
      start_req = 1'b0;
      abort_req = 1'b0;
      set_conv_complete_flag = 1'b0;
      clr_conv_complete_flag = 1'b0;

      // Address phase: latch target, reads answered here with side effects
      if (ph_ok)
      begin
         nxt_addr = haddr[ALP_AW-1:0];
         nxt_wr = hwrite;
         if (!hwrite)
         begin
            nxt_hrdata = rd_mux(haddr[ALP_AW-1:0], regs_ff, result_ff, st_ff == ALP_CONV);
            if ((haddr[ALP_AW-1:0] == ALP_OFS_RH)
               && (regs_ff.cfg.mode == ALP_MODE_10BIT))
            begin
               nxt_block = 1'b1; // see [RULE16]
            end
            if (haddr[ALP_AW-1:0] == ALP_OFS_RL)
            begin
               nxt_block = 1'b0; // see [RULE16]
               clr_conv_complete_flag = 1'b1;
            end
         end
      end

      // Data phase writes; any mode change invalidates a running conversion
      if (wr_ff)
      begin
         case (addr_ff)
            ALP_OFS_CFG:
            begin
               nxt_regs.cfg = alp_cfg_t'(wbyte); // see [RULE11]
               abort_req = 1'b1;
            end
            ALP_OFS_SC2:
            begin
               nxt_regs.sc2.trigger_select = wsc2.trigger_select; // see [RULE12]
               nxt_regs.sc2.compare_enable = wsc2.compare_enable;
               nxt_regs.sc2.compare_greater_select = wsc2.compare_greater_select;
               abort_req = 1'b1;
            end
            ALP_OFS_SC1:
            begin
               nxt_regs.sc1.complete_irq_enable = wsc1.complete_irq_enable; // see [RULE14]
               nxt_regs.sc1.continuous_select = wsc1.continuous_select; // see [RULE15]
               nxt_regs.sc1.channel_select = wsc1.channel_select;
               clr_conv_complete_flag = 1'b1;
               abort_req = 1'b1; // see [RULE19]
               if ((wsc1.channel_select != ALP_CH_OFF) && !regs_ff.sc2.trigger_select)
               begin
                  start_req = 1'b1; // see [RULE19]
               end
            end
            ALP_OFS_CVH:
            begin
               nxt_regs.cvh = wbyte; // see [RULE17]
               abort_req = 1'b1;
            end
            ALP_OFS_CVL:
            begin
               nxt_regs.cvl = wbyte; // see [RULE17]
               abort_req = 1'b1;
            end
            ALP_OFS_PC1:
            begin
               nxt_regs.pc1 = wbyte;
            end
            ALP_OFS_PC2:
            begin
               nxt_regs.pc2 = wbyte;
            end
            default:
            begin
               nxt_regs = regs_ff;
            end
         endcase
      end

      // Hardware trigger edge starts a conversion when idle
      if (sys_s.hw_trig && !trig_ff && regs_ff.sc2.trigger_select
         && (regs_ff.sc1.channel_select != ALP_CH_OFF) && (st_ff == ALP_IDLE))
      begin
         start_req = 1'b1; // see [RULE6] [RULE3]
      end

      // Stop3 entry on a synchronous clock source kills the conversion only
      if (sys_s.stop3 && !stop3_ff && !async_sel)
      begin
         abort_req = 1'b1; // see [RULE1] [RULE2] [RULE21]
      end

      // Completion handling; in stop3 with async clock this still runs
      if ((st_ff == ALP_CONV) && conv_done) // see [RULE5] [RULE4]
      begin
         nxt_st = ALP_IDLE;
         if (regs_ff.sc2.compare_enable && !cmp_true)
         begin
            start_req = regs_ff.sc1.continuous_select; // see [RULE15]
         end
         else if (block_ff && (regs_ff.cfg.mode == ALP_MODE_10BIT))
         begin
            start_req = 1'b1; // see [RULE20]
         end
         else
         begin
            nxt_result = regs_ff.sc2.compare_enable ? (res_now - cmp_val) : res_now;
            set_conv_complete_flag = 1'b1; // see [RULE7]
            start_req = regs_ff.sc1.continuous_select; // see [RULE15] [RULE6]
         end
      end

      if (abort_req)
      begin
         nxt_abort = (st_ff == ALP_CONV);
         nxt_st = ALP_IDLE; // see [RULE1]
      end
      if (start_req && !halted)
      begin
         nxt_st = ALP_CONV;
         nxt_start = 1'b1;
      end

      // Hardware set wins over a same-cycle clear
      if (clr_conv_complete_flag)
      begin
         nxt_regs.sc1.conv_complete_flag = 1'b0;
      end
      if (set_conv_complete_flag)
      begin
         nxt_regs.sc1.conv_complete_flag = 1'b1; // see [RULE7]
      end

      // Stop1/stop2: converter off and every register back to reset
      if (sys_s.deep_stop)
      begin
         nxt_regs = regs_reset(); // see [RULE9] [RULE21]
         nxt_result = ALP_RES_RST;
         nxt_block = 1'b0;
         nxt_st = ALP_IDLE;
         nxt_start = 1'b0;
         nxt_abort = (st_ff == ALP_CONV); // see [RULE9]
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         regs_ff <= regs_reset();
         result_ff <= ALP_RES_RST;
         block_ff <= 1'b0;
         st_ff <= ALP_IDLE;
         start_ff <= 1'b0;
         abort_ff <= 1'b0;
         addr_ff <= '0;
         wr_ff <= 1'b0;
         hrdata_ff <= '0;
         trig_ff <= 1'b0;
         stop3_ff <= 1'b0;
      end
      else
      begin
         regs_ff <= nxt_regs;
         result_ff <= nxt_result;
         block_ff <= nxt_block;
         st_ff <= nxt_st;
         start_ff <= nxt_start;
         abort_ff <= nxt_abort;
         addr_ff <= nxt_addr;
         wr_ff <= nxt_wr;
         hrdata_ff <= nxt_hrdata;
         trig_ff <= nxt_trig;
         stop3_ff <= nxt_stop3;
      end
   end

   // Zero-wait slave, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_ff;

   assign conv_start = start_ff;
   assign conv_abort = abort_ff;
   assign conv_channel = regs_ff.sc1.channel_select;
   assign conv_cfg = regs_ff.cfg;
   // Wake request to the system while the flag is pending and enabled
   assign conv_irq = regs_ff.sc1.conv_complete_flag
      && regs_ff.sc1.complete_irq_enable; // see [RULE7]
   assign pin_analog_en = PINS'({regs_ff.pc2, regs_ff.pc1}); // see [RULE18]

endmodule : alp_ctrl
`default_nettype wire

// ### sim/alp_ctrl_assertions.sv
// Port checker for the converter control block
`timescale 1ns/1ps
`default_nettype none
module alp_ctrl_chk
   import alp_pkg::*;
#(
   parameter int PINS = 16
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic stop3_req,
   input wire logic deep_stop_req,
   input wire logic conv_done,
   input wire logic conv_start,
   input wire logic conv_abort,
   input wire logic [4:0] conv_channel,
   input wire alp_cfg_t conv_cfg,
   input wire logic conv_irq,
   input wire logic [PINS-1:0] pin_analog_en
);
   logic busy_ff;
   logic nxt_busy;
   logic asy;
   logic sc1_wr;
   assign asy = conv_cfg.input_clock_select == ALP_CLK_ASYNC;
   assign sc1_wr = hsel && hready && htrans == ALP_HTRANS_NONSEQ && hwrite
      && haddr[7:0] == ALP_OFS_SC1;
   // Tracks a conversion in flight
   always_comb
   begin
      nxt_busy = conv_start | (busy_ff & ~conv_done & ~conv_abort);
   end
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         busy_ff <= 1'b0;
      else
         busy_ff <= nxt_busy;
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_ok;
      hreadyout && !hresp && hrdata[31:8] == 24'h000000;
   endproperty
   a_ok: assert property (p_ok) else $error("bus answer wrong");
   property p_deep;
      deep_stop_req [*4] |-> conv_cfg == ALP_CFG_RST && pin_analog_en == '0
         && conv_channel == ALP_CH_OFF && !conv_start && !conv_irq;
   endproperty
   a_deep: assert property (p_deep) else $error("deep stop not reset");
   // A start pulse in the same cycle counts as a conversion in flight
   property p_deep_ab;
      $rose(deep_stop_req) && (busy_ff || conv_start) |-> ##[1:5] (conv_abort || conv_done);
   endproperty
   a_deep_ab: assert property (p_deep_ab) else $error("deep stop no abort");
   property p_irq;
      $rose(conv_irq) |-> $past(conv_done);
   endproperty
   a_irq: assert property (p_irq) else $error("irq without completion");
   property p_s3ab;
      $rose(stop3_req) && busy_ff && !asy |-> ##[1:5] (conv_abort || conv_done);
   endproperty
   a_s3ab: assert property (p_s3ab) else $error("stop3 no abort");
   property p_s3idle;
      stop3_req [*4] ##0 !asy |-> !conv_start;
   endproperty
   a_s3idle: assert property (p_s3idle) else $error("start in stop3");
   property p_s3run;
      stop3_req && asy |-> !conv_abort;
   endproperty
   a_s3run: assert property (p_s3run) else $error("abort on async");
   property p_off;
      sc1_wr ##1 hwdata[4:0] == ALP_CH_OFF |=> !conv_start [*3];
   endproperty
   a_off: assert property (p_off) else $error("start on channel off");
   c_ab: cover property (conv_abort);
   c_irq: cover property ($rose(conv_irq));
   c_s3: cover property (stop3_req && asy && conv_done);
endmodule : alp_ctrl_chk
bind alp_ctrl alp_ctrl_chk #(.PINS(PINS)) u_chk (.hclk, .hresetn, .hsel, .haddr,
   .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .stop3_req,
   .deep_stop_req, .conv_done, .conv_start, .conv_abort, .conv_channel, .conv_cfg,
   .conv_irq, .pin_analog_en);
`default_nettype wire

// ### sim/alp_conv_model.sv
// Behavioural model of the analog converter
`timescale 1ns/1ps
`default_nettype none
module alp_conv_model
   import alp_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic start,
   input wire logic abort,
   input wire logic [ALP_RES_W-1:0] val,
   input wire logic [7:0] dly,
   output logic done,
   output logic [ALP_RES_W-1:0] data
);
   logic [7:0] cnt_ff;
   logic [7:0] nxt_cnt;
   logic [ALP_RES_W-1:0] last_ff;
   logic [ALP_RES_W-1:0] nxt_last;
   assign done = cnt_ff == 8'h01;
   // Data is only meaningful with done
   assign data = done ? val : ~last_ff;
   always_comb
   begin
      nxt_cnt = start ? dly : (abort ? 8'h00 : (cnt_ff != 8'h00 ? cnt_ff - 8'h01 : cnt_ff));
      nxt_last = done ? val : last_ff;
   end
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cnt_ff <= 8'h00;
         last_ff <= '0;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
         last_ff <= nxt_last;
      end
   end
endmodule : alp_conv_model
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import alp_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = '0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = '0;
   logic stop3_req = 1'b0;
   logic deep_stop_req = 1'b0;
   logic hw_trig = 1'b0;
   logic [9:0] val = 10'h000;
   logic [7:0] dly = 8'h14;
   logic hready, hresp, conv_done, conv_start, conv_abort, conv_irq;
   logic [31:0] hrdata, rd;
   logic [9:0] conv_data;
   logic [4:0] conv_channel;
   alp_cfg_t conv_cfg;
   logic [15:0] pin_analog_en;
   int n_mismatch = 0;
   int n_checks = 0;
   int n_start = 0;
   int n_abort = 0;
   int s, a;
   always #12.5 hclk = ~hclk;
   // Pulse counters sample off the launching edge
   always @(negedge hclk)
   begin
      if (conv_start === 1'b1)
         n_start++;
      if (conv_abort === 1'b1)
         n_abort++;
   end
   alp_ctrl #(.PINS(16)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata, .stop3_req,
      .deep_stop_req, .hw_trig, .conv_done, .conv_data, .conv_start, .conv_abort,
      .conv_channel, .conv_cfg, .conv_irq, .pin_analog_en);
   alp_conv_model u_adc (.hclk, .hresetn, .start(conv_start), .abort(conv_abort),
      .val, .dly, .done(conv_done), .data(conv_data));
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : test_done
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] e);
      n_checks++;
      if (seen !== e)
      begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", n, e, seen);
      end
   endtask : chk
   // Waits for n_start to reach t, or for the interrupt when t is 0
   task automatic wt(input int t);
      for (int i = 0; i < 400; i++)
      begin
         @(posedge hclk);
         if (t == 0 ? conv_irq === 1'b1 : n_start >= t)
            return;
      end
      n_mismatch++;
      test_done();
   endtask : wt
   // Waits for hready sampled high at a rising edge
   task automatic hrdy;
      for (int i = 0; i < 16; i++)
      begin
         @(posedge hclk);
         if (hready === 1'b1)
            return;
      end
      n_mismatch++;
      test_done();
   endtask : hrdy
   task automatic bus(input logic w, input logic [7:0] ad, input logic [7:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= ALP_HTRANS_NONSEQ;
      haddr <= {24'h000000, ad};
      hwrite <= w;
      hrdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h000000, wd};
      hrdy();
      rd = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      bus(1'b1, ad, d);
   endtask : wr
   task automatic rdc(input logic [7:0] ad, input logic [7:0] e, input string n);
      bus(1'b0, ad, 8'h00);
      chk(n, rd, {24'h000000, e});
   endtask : rdc
   task automatic trig;
      @(posedge hclk);
      hw_trig <= 1'b1;
      repeat (4) @(posedge hclk);
      hw_trig <= 1'b0;
   endtask : trig
   task automatic t_rst;
      logic [7:0] ad [10] = '{ALP_OFS_CFG, ALP_OFS_SC2, ALP_OFS_SC1, ALP_OFS_RH,
         ALP_OFS_RL, ALP_OFS_CVH, ALP_OFS_CVL, ALP_OFS_PC1, ALP_OFS_PC2, 8'h40};
      wr(8'h40, 8'hFF);
      foreach (ad[i])
         rdc(ad[i], ad[i] == ALP_OFS_SC1 ? ALP_SC1_RST : 8'h00, "reset value");
      chk("channel", conv_channel, ALP_CH_OFF);
   endtask : t_rst
   task automatic t_cfg;
      wr(ALP_OFS_CFG, 8'h98);
      rdc(ALP_OFS_CFG, 8'h98, "cfg");
      chk("cfg port", conv_cfg, 8'h98);
      wr(ALP_OFS_SC2, 8'hFC);
      rdc(ALP_OFS_SC2, 8'h70, "sc2");
      wr(ALP_OFS_SC2, 8'h00);
      wr(ALP_OFS_CVH, 8'h03);
      wr(ALP_OFS_CVL, 8'h5A);
      rdc(ALP_OFS_CVH, 8'h03, "cvh");
      rdc(ALP_OFS_CVL, 8'h5A, "cvl");
   endtask : t_cfg
   task automatic t_single;
      val = 10'h2A5;
      s = n_start;
      wr(ALP_OFS_SC1, 8'h41);
      rdc(ALP_OFS_SC2, 8'h80, "active");
      chk("channel", conv_channel, 5'h01);
      wt(0);
      rdc(ALP_OFS_SC1, 8'hC1, "complete");
      rdc(ALP_OFS_RH, 8'h02, "rh");
      rdc(ALP_OFS_RL, 8'hA5, "rl");
      rdc(ALP_OFS_SC1, 8'h41, "flag clear");
      chk("single", n_start, s + 1);
   endtask : t_single
   task automatic t_block;
      val = 10'h155;
      wr(ALP_OFS_SC1, 8'h41);
      wt(0);
      rdc(ALP_OFS_RH, 8'h01, "rh");
      val = 10'h0CC;
      s = n_start;
      wr(ALP_OFS_SC1, 8'h41);
      wt(s + 2);
      rdc(ALP_OFS_SC1, 8'h41, "blocked flag");
      rdc(ALP_OFS_RL, 8'h55, "kept rl");
      wt(0);
      rdc(ALP_OFS_RH, 8'h00, "rh");
      rdc(ALP_OFS_RL, 8'hCC, "rl");
   endtask : t_block
   task automatic t_off;
      dly = 8'h3C;
      s = n_start;
      a = n_abort;
      wr(ALP_OFS_SC1, 8'h41);
      wr(ALP_OFS_SC1, 8'h5F);
      repeat (10) @(posedge hclk);
      chk("off starts", n_start, s + 1);
      chk("off aborts", n_abort, a + 1);
   endtask : t_off
   task automatic t_s3;
      wr(ALP_OFS_SC2, 8'h40);
      wr(ALP_OFS_SC1, 8'h41);
      s = n_start;
      a = n_abort;
      trig();
      wt(s + 1);
      stop3_req <= 1'b1;
      repeat (6) @(posedge hclk);
      chk("s3 abort", n_abort, a + 1);
      trig();
      repeat (8) @(posedge hclk);
      stop3_req <= 1'b0;
      repeat (20) @(posedge hclk);
      chk("no resume", n_start, s + 1);
      rdc(ALP_OFS_SC2, 8'h40, "idle");
      rdc(ALP_OFS_RH, 8'h00, "rh");
      rdc(ALP_OFS_RL, 8'hCC, "rl");
      trig();
      wt(s + 2);
      chk("resume", n_start, s + 2);
      wt(0);
   endtask : t_s3
   task automatic t_as;
      dly = 8'h1E;
      val = 10'h2F0;
      wr(ALP_OFS_CFG, 8'h9B);
      wr(ALP_OFS_SC2, 8'h00);
      s = n_start;
      a = n_abort;
      wr(ALP_OFS_SC1, 8'h61);
      wt(s + 1);
      stop3_req <= 1'b1; // No pending block
      wt(0);
      wt(s + 2);
      chk("s3 run", n_abort, a);
      stop3_req <= 1'b0;
      wr(ALP_OFS_SC1, 8'h5F);
      rdc(ALP_OFS_RH, 8'h02, "rh");
      rdc(ALP_OFS_RL, 8'hF0, "rl");
   endtask : t_as
   // Compare at or above 0x100: a low result is dropped, a high one stored as difference
   task automatic t_cmp;
      wr(ALP_OFS_SC2, 8'h30);
      wr(ALP_OFS_CVH, 8'h01);
      wr(ALP_OFS_CVL, 8'h00);
      val = 10'h0F0;
      wr(ALP_OFS_SC1, 8'h41);
      repeat (40) @(posedge hclk);
      rdc(ALP_OFS_SC1, 8'h41, "cmp false");
      val = 10'h180;
      wr(ALP_OFS_SC1, 8'h41);
      wt(0);
      rdc(ALP_OFS_RH, 8'h00, "cmp rh");
      rdc(ALP_OFS_RL, 8'h80, "cmp rl");
      wr(ALP_OFS_SC2, 8'h00);
   endtask : t_cmp
   task automatic t_deep;
      wr(ALP_OFS_PC1, 8'h02);
      wr(ALP_OFS_PC2, 8'h80);
      @(negedge hclk);
      chk("pins", pin_analog_en, 16'h8002);
      dly = 8'h3C;
      wr(ALP_OFS_SC1, 8'h41);
      a = n_abort;
      deep_stop_req <= 1'b1;
      repeat (6) @(posedge hclk);
      chk("deep abort", n_abort, a + 1);
      chk("deep pins", pin_analog_en, 16'h0000);
      deep_stop_req <= 1'b0;
      repeat (3) @(posedge hclk);
      t_rst();
   endtask : t_deep
   initial
   begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      t_rst();
      t_cfg();
      t_single();
      t_block();
      t_off();
      t_s3();
      t_as();
      t_cmp();
      t_deep();
      test_done();
   end
endmodule : tb
`default_nettype wire
